// *** adc_serial_pkg.sv ***
package adc_serial_pkg;
  // Clock rates
  localparam int REF_CLK_HZ = 200_000_000; // Block clock, 5 ns period
  localparam int OSC_HZ = 4_000_000; // Internal conversion oscillator
  localparam int OSC_DIV = REF_CLK_HZ / OSC_HZ; // Block cycles per oscillator tick
  localparam int CONV_OSC_TICKS = 16; // Oscillator ticks per conversion
  // Reference wake time after full power-down
  localparam int REF_WAKE_MS = 5;
  localparam int REF_WAKE_CYCLES = (REF_CLK_HZ / 1000) * REF_WAKE_MS;
  // Pin synchroniser lanes
  localparam int NPINS = 4;
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DIN = 2;
  localparam int PIN_FS = 3;
  localparam logic [NPINS-1:0] PIN_IDLE = 4'h9; // Chip select and frame sync idle high, no false edge
  // Frame layout
  localparam int CMD_BITS = 8;
  localparam int RESULT_BITS = 16;
  localparam int FRAME_BITS = 24;
  localparam logic [2:0] CMD_LAST = 3'h7; // Index of last command bit
  localparam logic [1:0] TRAIL_BITS = 2'h0; // trailing_bit_hi, trailing_bit_lo
  localparam logic [5:0] FRAME_PAD = 6'h00;
  localparam logic [6:0] DSP_PAD = 7'h00;
  // Command byte fields
  localparam int CMD_SCAN_BIT = 0;
  localparam int CMD_CH_LSB = 4;
  localparam int CH_BITS = 3;
  localparam logic [3:0] CONV_LAST = 4'hf; // CONV_OSC_TICKS - 1

  // Gray along OFF -> CMD -> CONV -> SHIFT
  typedef enum logic [2:0]
  {
    ST_OFF = 3'h0,
    ST_CMD = 3'h1,
    ST_CONV = 3'h3,
    ST_SHIFT = 3'h2,
    ST_DSP_IDLE = 3'h6
  } phase_t;

  // Result word, two trailing bits, then zeros
  function automatic logic [FRAME_BITS-1:0] build_frame(input logic [RESULT_BITS-1:0] r);
    return {r, TRAIL_BITS, FRAME_PAD};
  endfunction

  // Channel field of a command byte
  function automatic logic [CH_BITS-1:0] cmd_channel(input logic [CMD_BITS-1:0] c);
    return c[CMD_CH_LSB +: CH_BITS];
  endfunction
endpackage

// *** pin_sync_if.sv ***
`timescale 1ns/1ps
interface pin_sync_if #(parameter int N = 4);
  logic [N-1:0] level; // Filtered pin levels
  logic [N-1:0] rise; // One-cycle rising pulses
  logic [N-1:0] fall; // One-cycle falling pulses
  modport producer (output level, rise, fall);
  modport consumer (input level, rise, fall);
endinterface

// *** pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync
  import adc_serial_pkg::*;
#(
  parameter int N = NPINS,
  parameter logic [N-1:0] IDLE = PIN_IDLE
)
(
  input wire logic ref_clk, // Block clock
  input wire logic rst, // Synchronous reset, high
  input wire logic clk_en, // Freezes state while low
  input wire logic [N-1:0] pins, // Raw asynchronous pins
  pin_sync_if.producer sif // Filtered levels and edges
);
  logic [N-1:0] s1_reg; // First stage, read only by s2
  logic [N-1:0] s2_reg;
  logic [N-1:0] s3_reg;
  logic [N-1:0] level_reg; // Accepted level
  logic [N-1:0] rise_reg;
  logic [N-1:0] fall_reg;
  logic [N-1:0] take; // Stages agree on a new level

  assign take = ~(s2_reg ^ s3_reg) & (s3_reg ^ level_reg);

  // Three-stage chain
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1_reg <= IDLE;
      s2_reg <= IDLE;
      s3_reg <= IDLE;
    end
    else if (clk_en)
    begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      level_reg <= IDLE;
      rise_reg <= '0;
      fall_reg <= '0;
    end
    else if (clk_en)
    begin
      level_reg <= level_reg ^ take;
      rise_reg <= take & s3_reg;
      fall_reg <= take & ~s3_reg;
    end
  end

  assign sif.level = level_reg;
  assign sif.rise = rise_reg;
  assign sif.fall = fall_reg;
endmodule

// *** adc_serial_readout_interface.sv ***
`timescale 1ns/1ps
module adc_serial_readout_interface
  import adc_serial_pkg::*;
#(
  parameter int WAKE_CYCLES = REF_WAKE_CYCLES // Shorten in simulation
)
(
  input wire logic ref_clk, // Block clock, 200 MHz
  input wire logic rst, // Synchronous reset, high
  input wire logic clk_en, // Freezes all state while low
  input wire logic cs_n, // Chip select pin, low active
  input wire logic sclk, // Serial clock pin
  input wire logic din, // Serial data in pin
  input wire logic frame_sync_in, // Frame sync from processor
  input wire logic ext_clock_mode, // 1: serial clock times conversion
  input wire logic [RESULT_BITS-1:0] sample_data, // Result from converter core
  output logic dout, // Serial data out pin
  output logic frame_sync_out, // Frame sync to processor
  output logic sample_req, // Pulse: core samples now
  output logic [CH_BITS-1:0] channel, // Commanded channel
  output logic scan_en, // Channel scanning allowed
  output logic osc_run, // Internal oscillator enabled
  output logic conv_busy, // Conversion in progress
  output logic dsp_mode, // Frame-sync mode active
  output logic ref_ready // Reference settled after wake
);
  localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES);
  localparam logic [5:0] OSC_LAST = 6'(OSC_DIV - 1);

  pin_sync_if #(.N(NPINS)) sif (); // Synchronised pins

  pin_sync #(.N(NPINS), .IDLE(PIN_IDLE)) u_sync
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pins({frame_sync_in, din, sclk, cs_n}),
    .sif(sif.producer)
  );

  phase_t state_reg; // Transfer phase
  logic dsp_reg; // Frame-sync mode latched
  logic [2:0] bit_reg; // Command bits taken
  logic [CMD_BITS-1:0] cmd_reg; // Command shifter
  logic [CH_BITS-1:0] ch_reg; // Channel latched
  logic scan_reg; // Scan request latched
  logic [FRAME_BITS-1:0] shift_reg; // Output shifter
  logic fso_reg; // Frame-sync out
  logic [5:0] osc_reg; // Oscillator divider
  logic [3:0] conv_reg; // Oscillator ticks into conversion
  logic [WAKE_W-1:0] wake_reg; // Reference wake counter
  logic cs_high, cs_fall, sclk_rise, sclk_fall, fs_rise;
  logic cmd_done_std, cmd_done_dsp, osc_tick, conv_done_int, load_std;
  logic [CMD_BITS-1:0] cmd_full; // Command byte including the bit now latching
  logic msb_reg; // Result MSB loaded with frame-sync out

  assign cs_high = sif.level[PIN_CS];
  assign cs_fall = sif.fall[PIN_CS];
  assign sclk_rise = sif.rise[PIN_SCLK] & ~cs_high;
  assign sclk_fall = sif.fall[PIN_SCLK] & ~cs_high;
  assign fs_rise = sif.rise[PIN_FS] & dsp_reg & ~cs_high;
  // Command byte complete; DSP samples on the eighth rise
  assign cmd_done_std = (state_reg == ST_CMD) & ~dsp_reg & sclk_fall & (bit_reg == CMD_LAST);
  assign cmd_done_dsp = (state_reg == ST_CMD) & dsp_reg & sclk_rise & (bit_reg == CMD_LAST);
  assign osc_tick = osc_run & (osc_reg == OSC_LAST);
  assign conv_done_int = (state_reg == ST_CONV) & osc_tick & (conv_reg == CONV_LAST);
  assign load_std = (cmd_done_std & ext_clock_mode) | conv_done_int;
  assign cmd_full = {cmd_reg[CMD_BITS-2:0], sif.level[PIN_DIN]};

  // Mode latched only at chip select fall
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      dsp_reg <= 1'b0;
    else if (clk_en)
    begin
      if (cs_high || !ext_clock_mode)
        dsp_reg <= 1'b0;
      else if (cs_fall)
        dsp_reg <= ~sif.level[PIN_FS];
      // Otherwise held while select stays low
    end
  end

  // Phase sequencing
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_reg <= ST_OFF;
    else if (clk_en)
    begin
      if (cs_high)
        state_reg <= ST_OFF; // Select high aborts and shuts down
      else if (cs_fall)
        // Mode decided from the pin directly, dsp_reg updates this same edge
        state_reg <= (~sif.level[PIN_FS] & ext_clock_mode) ? ST_DSP_IDLE : ST_CMD;
      else if (fs_rise)
        state_reg <= ST_CMD;
      else
      begin
        unique case (state_reg)
          ST_CMD:
          begin
            if (cmd_done_dsp || (cmd_done_std && ext_clock_mode))
              state_reg <= ST_SHIFT;
            else if (cmd_done_std)
              state_reg <= ST_CONV; // Oscillator takes over
          end
          ST_CONV:
          begin
            if (conv_done_int)
              state_reg <= ST_SHIFT;
          end
          ST_OFF, ST_SHIFT, ST_DSP_IDLE:
            state_reg <= state_reg; // Leave only on select or sync
          default:
            state_reg <= ST_OFF; // Illegal code
        endcase
      end
    end
  end

  // Command input, latched on the falling edge
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bit_reg <= '0;
      cmd_reg <= '0;
    end
    else if (clk_en)
    begin
      if (cs_fall || fs_rise)
        bit_reg <= '0;
      else if ((state_reg == ST_CMD) && sclk_fall)
      begin
        bit_reg <= bit_reg + 3'h1;
        cmd_reg <= {cmd_reg[CMD_BITS-2:0], sif.level[PIN_DIN]};
      end
    end
  end

  // Channel and scan taken when the command completes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ch_reg <= '0;
      scan_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (cmd_done_std)
      begin
        // Scan bit is the last one in, so take it from the full byte
        ch_reg <= cmd_channel(cmd_full);
        scan_reg <= cmd_full[CMD_SCAN_BIT];
      end
      else if (cmd_done_dsp)
      begin
        // Last bit not latched yet; channel field already complete
        ch_reg <= cmd_channel({cmd_reg[CMD_BITS-2:0], 1'b0});
        scan_reg <= 1'b0;
      end
    end
  end

  // Output shifter; leading zero byte falls out of clearing it at select fall or frame-sync rise
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      shift_reg <= '0;
    else if (clk_en)
    begin
      if (cs_high || cs_fall || fs_rise)
        shift_reg <= '0;
      else if (load_std)
        shift_reg <= build_frame(sample_data);
      else if (cmd_done_dsp)
        shift_reg <= {1'b0, sample_data, DSP_PAD}; // MSB on the ninth rise
      else if ((state_reg == ST_SHIFT) && (dsp_reg ? sclk_rise : sclk_fall))
        shift_reg <= {shift_reg[FRAME_BITS-2:0], 1'b0};
    end
  end

  // Frame-sync out lasts one serial clock period
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      fso_reg <= 1'b0;
    else if (clk_en)
    begin
      if (cmd_done_dsp)
        fso_reg <= 1'b1;
      else if (cs_high || sclk_rise)
        fso_reg <= 1'b0;
    end
  end

  // Result MSB kept beside frame-sync out so its check needs no deep history
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      msb_reg <= 1'b0;
    else if (clk_en && cmd_done_dsp)
      msb_reg <= sample_data[RESULT_BITS-1];
  end

  // Internal oscillator; dead in external mode to keep the core quiet
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      osc_reg <= '0;
      conv_reg <= '0;
    end
    else if (clk_en)
    begin
      if (!osc_run)
      begin
        osc_reg <= '0;
        conv_reg <= '0;
      end
      else if (osc_tick)
      begin
        osc_reg <= '0;
        conv_reg <= conv_reg + 4'h1;
      end
      else
        osc_reg <= osc_reg + 6'h1;
    end
  end

  // Reference wake timer, restarts on every shutdown
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wake_reg <= '0;
    else if (clk_en)
    begin
      if (cs_high)
        wake_reg <= '0;
      else if (wake_reg != WAKE_LAST)
        wake_reg <= wake_reg + WAKE_W'(1);
    end
  end

  assign osc_run = (state_reg == ST_CONV) & ~ext_clock_mode;
  assign dout = shift_reg[FRAME_BITS-1];
  assign frame_sync_out = fso_reg;
  assign sample_req = cmd_done_std | cmd_done_dsp;
  assign channel = ch_reg;
  assign scan_en = scan_reg & ~dsp_reg;
  assign conv_busy = (state_reg == ST_CONV);
  assign dsp_mode = dsp_reg;
  assign ref_ready = (wake_reg == WAKE_LAST);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !clk_en);

  sequence s_dsp_sync;
    fs_rise;
  endsequence
  sequence s_cmd_fresh;
    (state_reg == ST_CMD) && (bit_reg == 3'h0) && !dout;
  endsequence
  // Ninth serial clock rise of an undisturbed frame-sync transfer
  sequence s_msb_due;
    frame_sync_out && sclk_rise && !fs_rise && (state_reg == ST_SHIFT);
  endsequence

  AST_OSC_OFF_EXT: assert property (ext_clock_mode |-> !osc_run && osc_reg == 6'h0)
    else $error("oscillator active in external clock mode");
  AST_DSP_NEEDS_EXT: assert property ($rose(dsp_reg) |-> $past(ext_clock_mode))
    else $error("frame-sync mode entered without external clock");
  AST_DSP_ENTRY: assert property (cs_fall && !sif.level[PIN_FS] && ext_clock_mode |=> dsp_reg)
    else $error("frame-sync low at select fall did not select DSP mode");
  AST_DSP_STAYS: assert property (dsp_reg && !cs_high && ext_clock_mode |=> dsp_reg)
    else $error("frame-sync mode lost while select low");
  AST_NO_SCAN: assert property (cmd_done_dsp |=> !scan_reg && !scan_en)
    else $error("scanning enabled in frame-sync mode");
  AST_ABORT_RESTART: assert property (s_dsp_sync |=> s_cmd_fresh)
    else $error("frame-sync pulse did not restart conversion");
  AST_FSO_MARKS_MSB: assert property (s_msb_due |=> dout == msb_reg)
    else $error("frame-sync out not followed by result");
  AST_FSO_WHEN: assert property ($rose(frame_sync_out) |-> $past(cmd_done_dsp) && state_reg == ST_SHIFT)
    else $error("frame-sync out without completed command");
  // Select rise in the load cycle clears the shifter instead
  AST_LOAD_FRAME: assert property (load_std && !cs_high |=> shift_reg == build_frame($past(sample_data)))
    else $error("result frame layout wrong");
  // Loading after an internal conversion happens while the link clock rests
  AST_DOUT_ON_FALL: assert property (!dsp_reg && state_reg == ST_SHIFT && $past(state_reg) != ST_CONV
    && $changed(dout) |-> $past(sclk_fall))
    else $error("output changed off a serial clock fall");
  // Only a select rise may cut the oscillator short
  AST_INT_CONV_LEN: assert property ($rose(osc_run) |-> (osc_run || cs_high) [*8])
    else $error("internal conversion ended too early");
endmodule

// *** host_model.sv ***
`timescale 1ns/1ps
// Serial master that sits on the far side of the block's pins
module host_model
  import adc_serial_pkg::*;
(
  input wire logic ref_clk, // Block clock
  input wire logic dout, // Serial data from block
  output logic cs_n, // Chip select, low active
  output logic sclk, // Serial clock, idles low
  output logic din, // Serial data to block
  output logic frame_sync_in // Frame sync to block
);
  // Idle pins; the link clock stands still between frames
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    frame_sync_in = 1'b1;
  end

  // Half link period, derived from the block clock itself
  task automatic half();
    // Link rate scaled with the block clock, not a real pin rate
    repeat (8) @(posedge ref_clk);
  endtask

  // Frame-sync level is set one edge ahead so it is stable at the select fall
  task automatic select(input logic fs);
    @(posedge ref_clk);
    frame_sync_in <= fs;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    half();
  endtask

  // Release the select; also cuts any frame short
  task automatic deselect();
    cs_n <= 1'b1;
    frame_sync_in <= 1'b1;
    half();
  endtask

  // Half link period wide pulse, then low for the other half
  task automatic fs_pulse();
    frame_sync_in <= 1'b1;
    half();
    frame_sync_in <= 1'b0;
    half();
  endtask

  // Data out on rise; input taken at rise (standard) or fall (frame sync)
  task automatic xfer(input int n, input logic [23:0] tx, input logic dsp, output logic [23:0] rx);
    rx = 24'h000000;
    for (int i = 0; i < n; i++)
    begin
      if (!dsp)
        rx = {rx[22:0], dout};
      sclk <= 1'b1;
      din <= tx[23 - i];
      half();
      if (dsp)
        rx = {rx[22:0], dout};
      sclk <= 1'b0;
      half();
    end
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import adc_serial_pkg::*;
  logic ref_clk, rst, clk_en, ext_clock_mode; // Clock, reset, enable, timing mode
  logic [15:0] sample_data; // Core result fed to block
  logic cs_n, sclk, din, frame_sync_in; // Pins from host
  logic dout, frame_sync_out, sample_req, scan_en, osc_run, conv_busy, dsp_mode, ref_ready;
  logic [2:0] channel; // Commanded channel
  logic busy_d, fso_seen; // Monitor state
  logic [23:0] rx; // Bits seen by host
  int mismatches, total_checks, req_count;

  // 200 MHz block clock
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  adc_serial_readout_interface #(.WAKE_CYCLES(20)) adc_serial_readout_interface_inst (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .cs_n(cs_n), .sclk(sclk), .din(din),
    .frame_sync_in(frame_sync_in), .ext_clock_mode(ext_clock_mode), .sample_data(sample_data),
    .dout(dout), .frame_sync_out(frame_sync_out), .sample_req(sample_req), .channel(channel),
    .scan_en(scan_en), .osc_run(osc_run), .conv_busy(conv_busy), .dsp_mode(dsp_mode),
    .ref_ready(ref_ready));

  host_model host_model_inst (.ref_clk(ref_clk), .dout(dout), .cs_n(cs_n), .sclk(sclk),
    .din(din), .frame_sync_in(frame_sync_in));

  // Core result flips once taken, so a late capture shows up as wrong data
  always @(posedge ref_clk)
  begin
    busy_d <= conv_busy;
    if (sample_req === 1'b1)
      req_count <= req_count + 1;
    if (frame_sync_out === 1'b1)
      fso_seen <= 1'b1;
    if ((sample_req === 1'b1 && ext_clock_mode) || (busy_d === 1'b1 && conv_busy === 1'b0))
      sample_data <= ~sample_data;
  end

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // All outputs quiet after reset
  task automatic t_reset();
    check("reset outputs", {13'h0, dout, frame_sync_out, sample_req, channel, scan_en, osc_run,
      conv_busy, dsp_mode, ref_ready}, 24'h0);
  endtask

  // Standard three-byte frame, serial clock timing
  task automatic t_std();
    ext_clock_mode <= 1'b1;
    sample_data <= 16'hc3a5;
    req_count = 0;
    host_model_inst.select(1'b1);
    repeat (20) @(posedge ref_clk);
    check("ref_ready", ref_ready, 24'h1);
    host_model_inst.xfer(24, {8'h51, 16'haaaa}, 1'b0, rx);
    check("std frame", rx, {8'h00, 16'hc3a5});
    check("std ctrl", {channel, scan_en, osc_run, conv_busy}, 24'h2c);
    check("req count", req_count, 24'h1);
    host_model_inst.deselect();
    check("ref_ready off", ref_ready, 24'h0);
  endtask

  // Internal oscillator times the conversion, link clock only moves data
  task automatic t_int();
    int n;
    ext_clock_mode <= 1'b0;
    sample_data <= 16'h3c5a;
    host_model_inst.select(1'b1);
    host_model_inst.xfer(8, {8'h20, 16'h0}, 1'b0, rx);
    check("osc on", {osc_run, conv_busy}, 24'h3);
    // Enable low for 100 cycles; the conversion must stretch by as much
    clk_en <= 1'b0;
    repeat (100) @(posedge ref_clk);
    clk_en <= 1'b1;
    check("frozen conv", {osc_run, conv_busy, channel}, 24'h1a);
    n = 0;
    // Link clock held low during the conversion
    while (conv_busy === 1'b1 && n < 1000)
    begin
      @(posedge ref_clk);
      n++;
    end
    check("conv length", (n >= 785 && n <= 800), 24'h1);
    repeat (4) @(posedge ref_clk);
    check("osc off", osc_run, 24'h0);
    host_model_inst.xfer(16, 24'h0, 1'b0, rx);
    check("int result", rx[15:0], 24'h3c5a);
    host_model_inst.deselect();
  endtask

  // Frame-sync mode refused in internal timing; select rise aborts a frame
  task automatic t_refuse();
    ext_clock_mode <= 1'b0;
    host_model_inst.select(1'b0);
    check("dsp refused", dsp_mode, 24'h0);
    host_model_inst.xfer(8, 24'hf00000, 1'b0, rx);
    check("abort busy", {conv_busy, osc_run}, 24'h3);
    host_model_inst.deselect();
    check("abort idle", {conv_busy, osc_run, dout}, 24'h0);
    ext_clock_mode <= 1'b1;
  endtask

  // Two frame-sync conversions under one select, second one restarted mid-way
  task automatic t_dsp();
    logic [15:0] v;
    host_model_inst.select(1'b0);
    check("dsp entry", {dsp_mode, scan_en}, 24'h2);
    for (int k = 0; k < 2; k++)
    begin
      v = k ? 16'h4e21 : 16'h9b17;
      sample_data <= v;
      fso_seen = 1'b0;
      host_model_inst.fs_pulse();
      if (k == 1)
      begin
        host_model_inst.xfer(4, 24'hffffff, 1'b1, rx);
        host_model_inst.fs_pulse();
      end
      host_model_inst.xfer(24, {8'h3d, 16'h5555}, 1'b1, rx);
      check("dsp frame", rx, {8'h00, v});
      check("dsp ctrl", {fso_seen, frame_sync_out, channel, scan_en}, 24'h26);
    end
    host_model_inst.deselect();
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    clk_en = 1'b1;
    ext_clock_mode = 1'b1;
    sample_data = 16'h0;
    busy_d = 1'b0;
    fso_seen = 1'b0;
    mismatches = 0;
    total_checks = 0;
    req_count = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_std();
    t_int();
    t_refuse();
    t_dsp();
    stop_test();
  end

  // Hang guard, several times the expected run
  initial
  begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule
